//--- rtl/plmc_top.v
// sixteen-macrocell logic array with group enables and clock selection
//
// Summary of operation
// - Sixteen outputs form four groups of four sharing one enable.
// - Each group enable picks the enable pin, an XOR of two terms, on or off.
// - Each flip-flop picks clock pin A or B on its own.
// - Active-low selection captures on the falling edge or latches on low.
// - Active-high selection captures on the rising edge or latches on high.
// - Eight dual-feedback and eight single-feedback cells share the pins.
// - Both cell kinds offer pin, /Q, buried and register-input feedback.
// - Only dual-feedback cells feed /Q and the pin back together while driving the pin; buried mode does so in both kinds.
// - One global node presets, resets and preloads; one node observes.
`timescale 1ns/1ns
`include "plmc_consts.vh"
module plmc_top (
    input  wire        CLK_SYS,
    input  wire        RST_B,
    input  wire        CLOCK_PIN_A,
    input  wire        CLOCK_PIN_B,
    input  wire        OUT_EN_B,
    input  wire [3:0]  DED_IN,
    input  wire [15:0] PIN_IN,
    output reg  [15:0] PIN_OUT,
    output reg  [15:0] PIN_OE_B,
    input  wire [11:0] S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [11:0] S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);
    reg  [7:0]  oe_sel_q;
    reg  [15:0] clk_sel_q;
    reg  [15:0] clk_pol_q;
    reg  [15:0] latch_q;
    reg  [15:0] preload_q;
    reg         observe_q;
    reg  [2:0]  mode_q [0:15];
    reg  [35:0] pt_mask_q [0:23];
    reg  [15:0] cell_q;
    reg         clk_a_q;
    reg         clk_b_q;
    reg  [23:0] pterm;
    reg  [15:0] pin_fb;
    reg  [15:0] q_fb;
    reg  [15:0] drive;
    reg  [15:0] cell_d;
    reg  [15:0] capture;
    reg  [15:0] oe_d;
    reg  [3:0]  grp_en;
    reg  [35:0] sig;
    reg  [31:0] rd_d;
    reg         rd_ok;
    reg         wr_ok;
    reg  [2:0]  md;
    reg         lvl;
    reg         prev;
    wire        wr_go;
    wire        rd_go;
    wire [11:0] wa;
    wire [4:0]  wpt;
    wire [4:0]  rpt;
    wire        wr_pt;
    wire        rd_pt;
    integer     i, j, k;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  strb;
        integer      b;
        begin
            for (b = 0; b < 4; b = b + 1) begin
                merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
            end
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  strb;
        begin
            merge16[7:0]  = strb[0] ? nw[7:0]  : old[7:0];
            merge16[15:8] = strb[1] ? nw[15:8] : old[15:8];
        end
    endfunction

    // address and data are taken together, one write in flight at a time
    assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~S_AXI_AWREADY
                   & ~S_AXI_BVALID;
    assign rd_go = S_AXI_ARVALID & ~S_AXI_ARREADY & ~S_AXI_RVALID;
    assign wa    = S_AXI_AWADDR;
    assign wpt   = wa[7:3];
    assign rpt   = S_AXI_ARADDR[7:3];
    assign wr_pt = (wa >= `PLMC_OFS_PTERM) && (wa <= `PLMC_PTERM_LAST);
    assign rd_pt = (S_AXI_ARADDR >= `PLMC_OFS_PTERM)
                   && (S_AXI_ARADDR <= `PLMC_PTERM_LAST);

    always @* begin
        // dual cells alone may drive the pin and return pin and /Q together
        for (i = 0; i < 16; i = i + 1) begin
            md = mode_q[i];
            // index bit 1 set marks a single cell
            if (md == `PLMC_MODE_OUT_BOTH && i[1]) begin
                md = `PLMC_MODE_OUT_Q;
            end
            pin_fb[i] = PIN_IN[i] & (md == `PLMC_MODE_OUT_PIN
                        || md == `PLMC_MODE_OUT_BOTH
                        || md == `PLMC_MODE_BURIED);
            q_fb[i]   = ~cell_q[i] & (md != `PLMC_MODE_OUT_PIN);
            drive[i]  = (md == `PLMC_MODE_OUT_PIN) || (md == `PLMC_MODE_OUT_Q)
                        || (md == `PLMC_MODE_OUT_BOTH);
        end
        sig = {DED_IN, q_fb, pin_fb};
        // unused literals are masked off; an empty term is true
        for (i = 0; i < 24; i = i + 1) begin
            pterm[i] = &(~pt_mask_q[i] | sig);
        end
        for (i = 0; i < 4; i = i + 1) begin
            case (oe_sel_q[i*2 +: 2])
                `PLMC_OE_PIN: grp_en[i] = ~OUT_EN_B;
                `PLMC_OE_XOR: grp_en[i] = pterm[16+i*2] ^ pterm[17+i*2];
                `PLMC_OE_ON:  grp_en[i] = 1'b1;
                default:      grp_en[i] = 1'b0;
            endcase
        end
        for (i = 0; i < 16; i = i + 1) begin
            // cells 4g..4g+3 share the enable of group g
            // float unless group enabled and cell drives
            oe_d[i]   = ~(grp_en[i/4] & drive[i]);
            cell_d[i] = (mode_q[i] == `PLMC_MODE_REG_IN) ? PIN_IN[i]
                        : pterm[i];
            prev = clk_sel_q[i] ? clk_b_q : clk_a_q;
            lvl  = clk_sel_q[i] ? CLOCK_PIN_B : CLOCK_PIN_A;
            // active high: rising edge or high-level latch
            // active low: falling edge or low-level latch
            if (!clk_pol_q[i]) begin
                lvl  = ~lvl;
                prev = ~prev;
            end
            capture[i] = latch_q[i] ? lvl : (lvl & ~prev);
        end
    end

    always @* begin
        rd_ok = 1'b1;
        rd_d  = 32'h00000000;
        if (rd_pt) begin
            rd_d = S_AXI_ARADDR[2] ? {28'h0000000, pt_mask_q[rpt][35:32]}
                   : pt_mask_q[rpt][31:0];
        end else begin
            case (S_AXI_ARADDR)
                `PLMC_OFS_CTRL:    rd_d = {28'h0000000, observe_q, 3'h0};
                `PLMC_OFS_OE_SEL:  rd_d = {24'h000000, oe_sel_q};
                `PLMC_OFS_CLK_SEL: rd_d = {16'h0000, clk_sel_q};
                `PLMC_OFS_CLK_POL: rd_d = {16'h0000, clk_pol_q};
                `PLMC_OFS_LATCH:   rd_d = {16'h0000, latch_q};
                `PLMC_OFS_PRELOAD: rd_d = {16'h0000, preload_q};
                // register state only visible while observing
                `PLMC_OFS_STATE:
                    rd_d = {PIN_IN, observe_q ? cell_q : 16'h0000};
                `PLMC_OFS_MODE_LO:
                    for (j = 0; j < 8; j = j + 1) begin
                        rd_d[j*3 +: 3] = mode_q[j];
                    end
                `PLMC_OFS_MODE_HI:
                    for (j = 0; j < 8; j = j + 1) begin
                        rd_d[j*3 +: 3] = mode_q[j+8];
                    end
                default: rd_ok = 1'b0;
            endcase
        end
        wr_ok = wr_pt || (wa <= `PLMC_OFS_MODE_HI && wa[1:0] == 2'h0);
    end

    always @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            oe_sel_q      <= `PLMC_OE_SEL_RST;
            clk_sel_q     <= 16'h0000;
            clk_pol_q     <= `PLMC_CLK_POL_RST;
            latch_q       <= 16'h0000;
            preload_q     <= 16'h0000;
            observe_q     <= 1'b0;
            cell_q        <= 16'h0000;
            clk_a_q       <= 1'b0;
            clk_b_q       <= 1'b0;
            PIN_OUT       <= 16'h0000;
            PIN_OE_B      <= 16'hFFFF;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `PLMC_RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RRESP   <= `PLMC_RESP_OKAY;
            S_AXI_RDATA   <= 32'h00000000;
            for (k = 0; k < 16; k = k + 1) begin
                mode_q[k] <= `PLMC_MODE_RST;
            end
            for (k = 0; k < 24; k = k + 1) begin
                pt_mask_q[k] <= 36'h000000000;
            end
        end else begin
            clk_a_q  <= CLOCK_PIN_A;
            clk_b_q  <= CLOCK_PIN_B;
            PIN_OE_B <= oe_d;
            // pins sample the register one cycle late; keeps outputs on flops
            PIN_OUT  <= cell_q;
            for (k = 0; k < 16; k = k + 1) begin
                if (capture[k]) begin
                    cell_q[k] <= cell_d[k];
                end
            end
            S_AXI_AWREADY <= wr_go;
            S_AXI_WREADY  <= wr_go;
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? `PLMC_RESP_OKAY : `PLMC_RESP_SLVERR;
                if (wr_pt) begin
                    if (wa[2]) begin
                        pt_mask_q[wpt][35:32] <= S_AXI_WSTRB[0]
                            ? S_AXI_WDATA[3:0] : pt_mask_q[wpt][35:32];
                    end else begin
                        pt_mask_q[wpt][31:0] <= merge(pt_mask_q[wpt][31:0],
                            S_AXI_WDATA, S_AXI_WSTRB);
                    end
                end
                case (wa)
                    `PLMC_OFS_CTRL: begin
                        if (S_AXI_WSTRB[0]) begin
                            observe_q <= S_AXI_WDATA[`PLMC_CTRL_OBSERVE];
                            // global node, reset over preset over load
                            if (S_AXI_WDATA[`PLMC_CTRL_RESET]) begin
                                cell_q <= 16'h0000;
                            end else if (S_AXI_WDATA[`PLMC_CTRL_PRESET]) begin
                                cell_q <= 16'hFFFF;
                            end else if (S_AXI_WDATA[`PLMC_CTRL_PRELOAD]) begin
                                cell_q <= preload_q;
                            end
                        end
                    end
                    `PLMC_OFS_OE_SEL:
                        oe_sel_q <= S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0]
                                    : oe_sel_q;
                    `PLMC_OFS_CLK_SEL:
                        clk_sel_q <= merge16(clk_sel_q, S_AXI_WDATA[15:0],
                                     S_AXI_WSTRB[1:0]);
                    `PLMC_OFS_CLK_POL:
                        clk_pol_q <= merge16(clk_pol_q, S_AXI_WDATA[15:0],
                                     S_AXI_WSTRB[1:0]);
                    `PLMC_OFS_LATCH:
                        latch_q <= merge16(latch_q, S_AXI_WDATA[15:0],
                                   S_AXI_WSTRB[1:0]);
                    `PLMC_OFS_PRELOAD:
                        preload_q <= merge16(preload_q, S_AXI_WDATA[15:0],
                                     S_AXI_WSTRB[1:0]);
                    `PLMC_OFS_MODE_LO:
                        for (k = 0; k < 8; k = k + 1) begin
                            mode_q[k] <= S_AXI_WDATA[k*3 +: 3];
                        end
                    `PLMC_OFS_MODE_HI:
                        for (k = 0; k < 8; k = k + 1) begin
                            mode_q[k+8] <= S_AXI_WDATA[k*3 +: 3];
                        end
                    default: ;
                endcase
            end
            S_AXI_ARREADY <= rd_go;
            if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
            if (rd_go) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_d;
                S_AXI_RRESP  <= rd_ok ? `PLMC_RESP_OKAY : `PLMC_RESP_SLVERR;
            end
        end
    end
endmodule

//--- rtl/plmc_consts.vh
// register map, field codes and reset values of the macrocell array
`ifndef PLMC_CONSTS_VH
`define PLMC_CONSTS_VH
`define PLMC_ADDR_W        12
`define PLMC_OFS_CTRL      12'h000
`define PLMC_OFS_OE_SEL    12'h004
`define PLMC_OFS_CLK_SEL   12'h008
`define PLMC_OFS_CLK_POL   12'h00C
`define PLMC_OFS_LATCH     12'h010
`define PLMC_OFS_PRELOAD   12'h014
`define PLMC_OFS_STATE     12'h018
`define PLMC_OFS_MODE_LO   12'h01C
`define PLMC_OFS_MODE_HI   12'h020
`define PLMC_OFS_PTERM     12'h100
`define PLMC_PTERM_LAST    12'h1BC
`define PLMC_CTRL_RESET    0
`define PLMC_CTRL_PRESET   1
`define PLMC_CTRL_PRELOAD  2
`define PLMC_CTRL_OBSERVE  3
`define PLMC_OE_PIN        2'h0
`define PLMC_OE_XOR        2'h1
`define PLMC_OE_ON         2'h2
`define PLMC_OE_OFF        2'h3
`define PLMC_OE_SEL_RST    8'hFF
`define PLMC_MODE_OUT_PIN  3'h0
`define PLMC_MODE_OUT_Q    3'h1
`define PLMC_MODE_OUT_BOTH 3'h2
`define PLMC_MODE_BURIED   3'h3
`define PLMC_MODE_REG_IN   3'h4
`define PLMC_MODE_RST      3'h1
`define PLMC_CLK_POL_RST   16'hFFFF
`define PLMC_RESP_OKAY     2'h0
`define PLMC_RESP_SLVERR   2'h2
`endif

//--- verification/plmc_assertions.sv
// port-level checks of the macrocell array
`timescale 1ns/1ns
`include "plmc_consts.vh"
module plmc_assertions (
    input wire        CLK_SYS,
    input wire        RST_B,
    input wire [15:0] PIN_OUT,
    input wire [15:0] PIN_OE_B,
    input wire        S_AXI_AWVALID,
    input wire        S_AXI_AWREADY,
    input wire        S_AXI_WVALID,
    input wire        S_AXI_WREADY,
    input wire        S_AXI_BVALID,
    input wire        S_AXI_BREADY,
    input wire [1:0]  S_AXI_BRESP,
    input wire        S_AXI_ARVALID,
    input wire        S_AXI_ARREADY,
    input wire        S_AXI_RVALID,
    input wire        S_AXI_RREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire [1:0]  S_AXI_RRESP
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    sequence wr_req;
        S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
    endsequence
    sequence wr_ans;
        S_AXI_AWREADY && S_AXI_WREADY && S_AXI_BVALID;
    endsequence
    wr_answer_a: assert property (wr_req |=> wr_ans)
        else $error("write not answered in one cycle");
    rd_answer_a: assert property (
        S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID
        |=> S_AXI_ARREADY && S_AXI_RVALID)
        else $error("read not answered in one cycle");
    b_release_a: assert property (
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response not released");
    r_release_a: assert property (
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read response not released");
    ready_pulse_a: assert property (S_AXI_AWREADY |=> !S_AXI_AWREADY)
        else $error("write ready longer than one cycle");
    err_data_a: assert property (
        S_AXI_RVALID && S_AXI_RRESP == `PLMC_RESP_SLVERR
        |-> S_AXI_RDATA == 32'h0)
        else $error("refused read returned data");
    resp_code_a: assert property (
        S_AXI_BVALID
        |-> S_AXI_BRESP inside {`PLMC_RESP_OKAY, `PLMC_RESP_SLVERR})
        else $error("illegal write response code");
    pins_reset_a: assert property (
        $rose(RST_B) |-> PIN_OE_B == 16'hFFFF && PIN_OUT == 16'h0000)
        else $error("pins not floated after reset");
endmodule

//--- verification/plmc_ext_model.sv
// external logic at the pins: clock pins, enable pin, inputs
`timescale 1ns/1ns
module plmc_ext_model (
    input  wire        clk,
    input  wire [15:0] pin_out,
    input  wire [15:0] pin_oe_b,
    output reg         clk_a = 1'b0,
    output reg         clk_b = 1'b0,
    output reg         en_b = 1'b1,
    output reg  [3:0]  ded = 4'h0,
    output wire [15:0] pin_in
);
    reg [15:0] float_q = 16'h5A5A;
    // released pin 1 toggles every cycle, pins 2 to 15 change often, pin 0 holds its start value
    always @(posedge clk) begin
        float_q <= ~float_q ^ {float_q[14:0], 1'b1};
    end
    assign pin_in = (~pin_oe_b & pin_out) | (pin_oe_b & float_q);
    task set_pin(input integer k, input v);
        begin
            case (k)
                0: clk_a <= v;
                1: clk_b <= v;
                2: en_b <= v;
                default: ded[0] <= v;
            endcase
        end
    endtask
endmodule

//--- verification/plmc_top_tb.sv
// self-checking bench: register bus, pin enables, clock selection
`timescale 1ns/1ns
`include "plmc_consts.vh"
module plmc_top_tb;
    logic        CLK_SYS, RST_B, S_AXI_AWVALID, S_AXI_WVALID;
    logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
    logic [11:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, rd;
    logic [3:0]  S_AXI_WSTRB;
    wire         CLOCK_PIN_A, CLOCK_PIN_B, OUT_EN_B, S_AXI_AWREADY;
    wire         S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    wire  [1:0]  S_AXI_BRESP, S_AXI_RRESP;
    wire  [3:0]  DED_IN;
    wire  [15:0] PIN_IN, PIN_OUT, PIN_OE_B;
    wire  [31:0] S_AXI_RDATA;
    integer      err_total, checks, cyc;
    plmc_top DUT (.CLK_SYS, .RST_B, .CLOCK_PIN_A, .CLOCK_PIN_B, .OUT_EN_B,
        .DED_IN, .PIN_IN, .PIN_OUT, .PIN_OE_B, .S_AXI_AWADDR, .S_AXI_AWVALID,
        .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
        .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
        .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
    plmc_ext_model EXT (.clk(CLK_SYS), .pin_out(PIN_OUT), .pin_oe_b(PIN_OE_B),
        .clk_a(CLOCK_PIN_A), .clk_b(CLOCK_PIN_B), .en_b(OUT_EN_B),
        .ded(DED_IN), .pin_in(PIN_IN));
    always #25 CLK_SYS = ~CLK_SYS;
    task final_report;
        begin
            $display("checks %0d mismatches %0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    // a hung handshake ends the run as a mismatch
    always @(posedge CLK_SYS) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            final_report;
        end
    end
    task cmp(input [63:0] nm, input [31:0] e, input [31:0] s);
        begin
            checks = checks + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("ERROR %0s expected %h seen %h", nm, e, s);
            end
        end
    endtask
    task axw(input [11:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge CLK_SYS);
            S_AXI_AWADDR <= a;
            S_AXI_WDATA <= d;
            S_AXI_AWVALID <= 1'b1;
            S_AXI_WVALID <= 1'b1;
            S_AXI_BREADY <= 1'b1;
            do begin
                @(posedge CLK_SYS);
                if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
                if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
            end while (S_AXI_BVALID !== 1'b1);
            S_AXI_BREADY <= 1'b0;
            cmp("bresp", {30'h0, er}, {30'h0, S_AXI_BRESP});
        end
    endtask
    task axr(input [11:0] a, input [1:0] er);
        begin
            @(posedge CLK_SYS);
            S_AXI_ARADDR <= a;
            S_AXI_ARVALID <= 1'b1;
            S_AXI_RREADY <= 1'b1;
            do begin
                @(posedge CLK_SYS);
                if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
            end while (S_AXI_RVALID !== 1'b1);
            S_AXI_RREADY <= 1'b0;
            rd = S_AXI_RDATA;
            cmp("rresp", {30'h0, er}, {30'h0, S_AXI_RRESP});
        end
    endtask
    // upper half of the state word shows live pins, so it is masked
    task chk(input [11:0] a, input [31:0] e, input [31:0] m);
        begin
            axr(a, `PLMC_RESP_OKAY);
            cmp("rdata", e, rd & m);
        end
    endtask
    task pin(input integer k, input v);
        begin
            @(posedge CLK_SYS);
            EXT.set_pin(k, v);
            repeat (3) @(posedge CLK_SYS);
        end
    endtask
    initial begin
        CLK_SYS = 1'b0;
        RST_B = 1'b0;
        S_AXI_AWVALID = 1'b0;
        S_AXI_WVALID = 1'b0;
        S_AXI_BREADY = 1'b0;
        S_AXI_ARVALID = 1'b0;
        S_AXI_RREADY = 1'b0;
        S_AXI_AWADDR = 12'h000;
        S_AXI_ARADDR = 12'h000;
        S_AXI_WDATA = 32'h0;
        S_AXI_WSTRB = 4'hF;
        err_total = 0;
        checks = 0;
        cyc = 0;
        repeat (2) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        cmp("oe_b", 32'hFFFF, {16'h0, PIN_OE_B});
        chk(`PLMC_OFS_OE_SEL, 32'hFF, 32'hFFFFFFFF);
        chk(`PLMC_OFS_CLK_POL, 32'hFFFF, 32'hFFFFFFFF);
        chk(`PLMC_OFS_MODE_LO, 32'h249249, 32'hFFFFFFFF);
        axr(12'h0FC, `PLMC_RESP_SLVERR);
        cmp("rdata", 32'h0, rd);
        axw(12'h0FC, 32'h1, `PLMC_RESP_SLVERR);
        $display("test reset values done");
        axw(`PLMC_OFS_PTERM + 12'h094, 32'h1, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_OE_SEL, 32'hE4, `PLMC_RESP_OKAY);
        pin(2, 1'b0);
        cmp("oe_b", 32'hF000, {16'h0, PIN_OE_B});
        pin(2, 1'b1);
        pin(3, 1'b1);
        cmp("oe_b", 32'hF0FF, {16'h0, PIN_OE_B});
        $display("test group enables done");
        axw(`PLMC_OFS_CTRL, 32'h8, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_CLK_SEL, 32'h2, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_CLK_POL, 32'hFFFD, `PLMC_RESP_OKAY);
        pin(1, 1'b1);
        chk(`PLMC_OFS_STATE, 32'h0, 32'hFFFF);
        pin(1, 1'b0);
        chk(`PLMC_OFS_STATE, 32'h2, 32'hFFFF);
        pin(0, 1'b1);
        chk(`PLMC_OFS_STATE, 32'hFFFF, 32'hFFFF);
        $display("test clock selection done");
        axw(`PLMC_OFS_CTRL, 32'h9, `PLMC_RESP_OKAY);
        chk(`PLMC_OFS_STATE, 32'h0, 32'hFFFF);
        axw(`PLMC_OFS_CTRL, 32'hA, `PLMC_RESP_OKAY);
        chk(`PLMC_OFS_STATE, 32'hFFFF, 32'hFFFF);
        axw(`PLMC_OFS_PRELOAD, 32'h1234, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_CTRL, 32'hC, `PLMC_RESP_OKAY);
        chk(`PLMC_OFS_STATE, 32'h1234, 32'hFFFF);
        cmp("pin_out", 32'h1234, {16'h0, PIN_OUT});
        axw(`PLMC_OFS_LATCH, 32'h1, `PLMC_RESP_OKAY);
        chk(`PLMC_OFS_STATE, 32'h1235, 32'hFFFF);
        $display("test global node and latch done");
        // cell 0 is dual, cell 2 single; terms 4 and 5 read their pins
        axw(`PLMC_OFS_MODE_LO, 32'h24928A, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_MODE_HI, 32'h249223, `PLMC_RESP_OKAY);
        chk(`PLMC_OFS_MODE_HI, 32'h249223, 32'hFFFFFFFF);
        axw(`PLMC_OFS_OE_SEL, 32'hEA, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_PTERM + 12'h020, 32'h1, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_PTERM + 12'h028, 32'h4, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_PRELOAD, 32'h5, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_CTRL, 32'hC, `PLMC_RESP_OKAY);
        axw(`PLMC_OFS_LATCH, 32'h31, `PLMC_RESP_OKAY);
        chk(`PLMC_OFS_STATE, 32'h15, 32'hFFFF);
        cmp("oe_b", 32'hF300, {16'h0, PIN_OE_B});
        S_AXI_WSTRB <= 4'h1;
        axw(`PLMC_OFS_PRELOAD, 32'hFFFF, `PLMC_RESP_OKAY);
        S_AXI_WSTRB <= 4'hF;
        chk(`PLMC_OFS_PRELOAD, 32'hFF, 32'hFFFFFFFF);
        $display("test feedback modes done");
        final_report;
    end
endmodule
bind plmc_top plmc_assertions u_chk (.CLK_SYS, .RST_B, .PIN_OUT, .PIN_OE_B,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP);
